// ==== core/fetx_cfg.svh ====
// Constants of the fast Ethernet transmit coding path.
`ifndef FETX_CFG_SVH
`define FETX_CFG_SVH
// Notes on behaviour
// - Every nibble sent while transmit enable is high becomes one 5-bit code-group.
// - Nibbles 0 to F map onto the fixed sixteen data code-groups.
// - Code-group 00100 is the halt symbol and marks an error.
// - The ten invalid code-groups are never produced.
// - Control or halt symbols inside a data field are flagged as a code error.
// - The first preamble byte is replaced by the start pair 11000 10001.
// - Dropping transmit enable appends the end pair 01101 00111.
// - After the end pair, idle 11111 is sent until the next frame.
// - An 11-bit closed-loop LFSR is XORed onto every serial bit.
// - The scrambler seed comes from the five address strap pins.
// - A bypass option passes the stream unscrambled to the NRZI stage.
// - NRZI encoding is always applied and cannot be bypassed.
// - The NRZI stage also yields MLT-3 values for internal loopback.
// - MLT-3 splits into two streams whose one events alternate.
// - Line words carry the NRZI bits as well as the MLT-3 pos and neg streams.
// - Nibbles become a 125 Mb/s line stream, five bits per clock.
// - Sequencing follows the standard 100BASE-TX transmit state machine.
`define FETX_CLK_MHZ 25
`define FETX_LINE_MBPS 125
`define FETX_SYM_W (`FETX_LINE_MBPS / `FETX_CLK_MHZ)
`define FETX_CG_DATA {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12, \
                      5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e}
`define FETX_CG_IDLE 5'h1f
`define FETX_CG_J 5'h18
`define FETX_CG_K 5'h11
`define FETX_CG_T 5'h0d
`define FETX_CG_R 5'h07
`define FETX_CG_HALT 5'h04
`define FETX_TAP_HI 10
`define FETX_TAP_LO 8
`define FETX_SEED_FILL 1'h1
`define FETX_SEED_WAIT 2'h2
`define FETX_FIFO_DEPTH 16
`endif

// ==== core/fetx_pkg.sv ====
// Types of the fast Ethernet transmit coding path.
package fetx_pkg;
`include "fetx_cfg.svh"
    typedef enum logic [3:0] {
        FETX_ST_IDLE = 4'h1,
        FETX_ST_K    = 4'h2,
        FETX_ST_DATA = 4'h4,
        FETX_ST_R    = 4'h8
    } fetx_state_t;
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] data;
    } fetx_nib_t;
    typedef struct packed {
        logic                   valid;
        logic [`FETX_SYM_W-1:0] nrzi;
        logic [`FETX_SYM_W-1:0] pos;
        logic [`FETX_SYM_W-1:0] neg;
    } fetx_line_t;
    typedef struct packed {
        logic [4:0]             strap1;
        logic [4:0]             strap2;
        logic [1:0]             wait_cnt;
        logic                   seeded;
        logic [10:0]            lfsr;
        fetx_state_t            st;
        logic [`FETX_SYM_W-1:0] sym;
        logic                   sym_vld;
        logic                   sym_data;
        logic [`FETX_SYM_W-1:0] scr;
        logic                   scr_vld;
        logic                   scr_err;
        logic                   lvl;
        logic [1:0]             phase;
        fetx_line_t             line;
        fetx_line_t             loop;
        logic                   code_err;
    } fetx_core_t;
endpackage

// ==== core/fetx_coder.sv ====
// Nibble FIFO and 4B/5B, scrambler, NRZI and MLT-3 transmit coding path.
`timescale 1ns/10ps
// ==========================================================
// Nibble FIFO
module fetx_fifo
    import fetx_pkg::*;
#(
    parameter int W     = 6,
    parameter int DEPTH = 16
)(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    input  wire logic         out_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [AW-1:0]           wr;
        logic [AW:0]             cnt;
        logic                    rdy;
    } fetx_fifo_s_t;

    fetx_fifo_s_t q;
    fetx_fifo_s_t d;
    logic         push;
    logic         pop;

    always_comb
    begin
        d = q;
        push = in_valid && q.rdy;
        pop = out_ready && (q.cnt != '0);
        if (push)
        begin
            d.mem[q.wr] = in_data;
            d.wr = q.wr + AW'(1);
        end
        if (pop)
        begin
            d.rd = q.rd + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Ready is registered so the MAC sees a clean flop output.
        d.rdy = d.cnt < (AW+1)'(DEPTH);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign in_ready = q.rdy;
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rd];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_fifo_full_ready: assert property ((q.cnt == (AW+1)'(DEPTH)) |-> !in_ready)
        else $error("fifo full but still ready");
    chk_fifo_count_step: assert property ((in_valid && in_ready && !out_ready)
        |=> q.cnt == $past(q.cnt) + (AW+1)'(1))
        else $error("fifo count did not grow on push");
endmodule

// ==========================================================
// Transmit coding path
module fetx_coder
    import fetx_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       mac_valid,
    input  fetx_nib_t       mac_nib,
    output logic            mac_ready,
    input  wire logic [4:0] phy_address_straps,
    input  wire logic       scram_bypass,
    input  wire logic       loop_enable,
    input  wire logic       line_ready,
    output fetx_line_t      line_out,
    output fetx_line_t      loop_out,
    output logic            code_err
);
    localparam logic [16*`FETX_SYM_W-1:0] CG_TAB = `FETX_CG_DATA;
    localparam fetx_core_t CORE_RST = '{st: FETX_ST_IDLE, default: '0};

    fetx_core_t             q;
    fetx_core_t             d;
    fetx_nib_t              head;
    logic                   head_vld;
    logic                   pop;
    logic                   run;
    logic [`FETX_SYM_W-1:0] sym;
    logic                   data_fld;
    fetx_state_t            nst;
    fetx_line_t             word;
    logic                   ks;
    logic [10:0]            sh;
    logic                   lv;
    logic [1:0]             ph;

    function automatic logic [`FETX_SYM_W-1:0] cg_of(input logic [3:0] n);
        return CG_TAB[int'(n)*`FETX_SYM_W +: `FETX_SYM_W];
    endfunction

    function automatic logic is_data(input logic [`FETX_SYM_W-1:0] s);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 16; i++)
            if (cg_of(4'(i)) == s)
                hit = 1'b1;
        return hit;
    endfunction

    function automatic logic is_invalid(input logic [`FETX_SYM_W-1:0] s);
        case (s)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
            5'h06, 5'h08, 5'h0c, 5'h10, 5'h19: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // The FIFO decouples the MAC from stalls of the line serialiser.
    fetx_fifo #(
        .W     ($bits(fetx_nib_t)),
        .DEPTH (`FETX_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (mac_valid),
        .in_data   (mac_nib),
        .in_ready  (mac_ready),
        .out_ready (pop && run),
        .out_valid (head_vld),
        .out_data  (head)
    );

    always_comb
    begin
        d = q;
        d.strap1 = phy_address_straps;
        d.strap2 = q.strap1;
        if (!q.seeded)
        begin
            if (q.wait_cnt == `FETX_SEED_WAIT)
            begin
                d.lfsr = {q.strap2, `FETX_SEED_FILL, q.strap2};
                d.seeded = 1'b1;
            end
            else
                d.wait_cnt = q.wait_cnt + 2'h1;
        end
        run = line_ready && q.seeded;

        sym = `FETX_CG_IDLE;
        data_fld = 1'b0;
        pop = 1'b0;
        nst = q.st;
        case (q.st)
            FETX_ST_IDLE:
            begin
                pop = head_vld;
                if (head_vld && head.en)
                begin
                    sym = `FETX_CG_J;
                    nst = FETX_ST_K;
                end
            end
            FETX_ST_K:
            begin
                pop = head_vld;
                if (head_vld && head.en)
                begin
                    sym = `FETX_CG_K;
                    nst = FETX_ST_DATA;
                end
                else if (head_vld)
                begin
                    sym = `FETX_CG_T;
                    nst = FETX_ST_R;
                end
                else
                begin
                    sym = `FETX_CG_HALT;
                    data_fld = 1'b1;
                end
            end
            FETX_ST_DATA:
            begin
                pop = head_vld;
                if (head_vld && head.en)
                begin
                    sym = head.er ? `FETX_CG_HALT : cg_of(head.data);
                    data_fld = 1'b1;
                end
                else if (head_vld)
                begin
                    sym = `FETX_CG_T;
                    nst = FETX_ST_R;
                end
                else
                begin
                    sym = `FETX_CG_HALT;
                    data_fld = 1'b1;
                end
            end
            FETX_ST_R:
            begin
                sym = `FETX_CG_R;
                nst = FETX_ST_IDLE;
                // A new frame waiting at the head is left for the idle state.
                pop = head_vld && !head.en;
            end
            default:
            begin
                nst = FETX_ST_IDLE;
            end
        endcase

        sh = q.lfsr;
        ks = 1'b0;
        for (int i = `FETX_SYM_W - 1; i >= 0; i--)
        begin
            ks = sh[`FETX_TAP_HI] ^ sh[`FETX_TAP_LO];
            sh = {sh[9:0], ks};
        end

        word = '0;
        word.valid = q.scr_vld;
        lv = q.lvl;
        ph = q.phase;
        for (int i = `FETX_SYM_W - 1; i >= 0; i--)
        begin
            lv = lv ^ q.scr[i];
            ph = ph + {1'b0, q.scr[i]};
            word.nrzi[i] = lv;
            word.pos[i] = ph == 2'h1;
            word.neg[i] = ph == 2'h3;
        end

        d.line.valid = 1'b0;
        d.loop.valid = 1'b0;
        d.code_err = 1'b0;
        if (run)
        begin
            d.st = nst;
            d.sym = sym;
            d.sym_vld = 1'b1;
            d.sym_data = data_fld;
            d.lfsr = sh;
            if (scram_bypass)
                d.scr = q.sym;
            else
            begin
                for (int i = `FETX_SYM_W - 1; i >= 0; i--)
                    d.scr[i] = q.sym[i] ^ q.lfsr[`FETX_TAP_HI - (`FETX_SYM_W - 1 - i)]
                        ^ q.lfsr[`FETX_TAP_LO - (`FETX_SYM_W - 1 - i)];
            end
            d.scr_vld = q.sym_vld;
            d.scr_err = q.sym_vld && q.sym_data && !is_data(q.sym);
            // Only words that reach the line may move the NRZI and MLT-3 state.
            if (q.scr_vld)
            begin
                d.lvl = lv;
                d.phase = ph;
            end
            d.code_err = q.scr_err;
            if (loop_enable)
            begin
                d.loop = word;
                d.line = '0;
                d.line.valid = q.scr_vld;
            end
            else
            begin
                d.line = word;
                d.loop = '0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            q <= CORE_RST;
        else
            q <= d;
    end

    assign line_out = q.line;
    assign loop_out = q.loop;
    assign code_err = q.code_err;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_frame_open;
        q.st == FETX_ST_IDLE ##1 q.st == FETX_ST_K;
    endsequence
    sequence s_frame_close;
        q.st == FETX_ST_DATA ##1 q.st == FETX_ST_R;
    endsequence

    chk_start_pair_j: assert property (s_frame_open |-> q.sym == `FETX_CG_J)
        else $error("start of frame not J");
    chk_start_pair_k: assert property ((q.st == FETX_ST_K ##1 q.st == FETX_ST_DATA)
        |-> q.sym == `FETX_CG_K)
        else $error("second start symbol not K");
    chk_end_pair: assert property (s_frame_close |-> q.sym == `FETX_CG_T
        ##1 (q.st != FETX_ST_IDLE || q.sym == `FETX_CG_R))
        else $error("end pair not T then R");
    chk_idle_fill: assert property ((run && q.st == FETX_ST_IDLE && !(head_vld && head.en))
        |=> q.sym == `FETX_CG_IDLE)
        else $error("idle code not sent between frames");
    chk_data_map: assert property ((run && q.st == FETX_ST_DATA && head_vld && head.en
        && !head.er) |=> q.sym == cg_of($past(head.data)))
        else $error("nibble mapped to wrong code-group");
    chk_halt_on_err: assert property ((run && q.st == FETX_ST_DATA && head_vld && head.en
        && head.er) |=> q.sym == `FETX_CG_HALT ##2 code_err)
        else $error("transmit error not turned into halt");
    chk_no_invalid: assert property (q.sym_vld |-> !is_invalid(q.sym))
        else $error("invalid code-group produced");
    chk_lfsr_alive: assert property (q.seeded |-> q.lfsr != '0)
        else $error("scrambler stuck at zero");
    chk_bypass_path: assert property ((run && scram_bypass) |=> q.scr == $past(q.sym))
        else $error("bypass did not pass symbol through");
    chk_nrzi_first: assert property ((run && !loop_enable && q.scr_vld)
        |=> line_out.nrzi[4] == ($past(q.lvl) ^ $past(q.scr[4])))
        else $error("NRZI first bit wrong");
    chk_mlt_split: assert property ((line_out.pos & line_out.neg) == '0)
        else $error("both MLT-3 streams active together");
endmodule

// ==== dv/fetx_mac_model.sv ====
// MAC side model that offers queued nibble entries to the coding path.
`timescale 1ns/10ps
// ==========================================================
// MAC transmit model
module fetx_mac_model
    import fetx_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic mac_ready,
    output logic      mac_valid,
    output fetx_nib_t mac_nib
);
    fetx_nib_t q[$];
    int        taken;

    initial
    begin
        mac_valid = 1'b0;
        mac_nib   = '0;
        taken     = 0;
    end

    task automatic push(input fetx_nib_t n);
        q.push_back(n);
    endtask

    // The entry is held until it is taken, so no nibble is lost or repeated.
    always @(posedge ref_clk)
    begin
        if (mac_valid && mac_ready)
        begin
            void'(q.pop_front());
            taken++;
        end
        #1;
        if (q.size() != 0)
        begin
            mac_valid = 1'b1;
            mac_nib   = q[0];
        end
        else
        begin
            mac_valid    = 1'b0;
            mac_nib.data = ~mac_nib.data;
        end
    end
endmodule

// ==== dv/fetx_coder_bench.sv ====
// Self-checking bench of the transmit coding path.
`timescale 1ns/10ps
// ==========================================================
// Bench top
module fetx_coder_bench
    import fetx_pkg::*;
;
    localparam logic [4:0] CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                       5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    localparam logic [4:0] C_J = 5'h18, C_K = 5'h11, C_T = 5'h0d, C_R = 5'h07;
    localparam logic [4:0] C_H = 5'h04, C_I = 5'h1f;
    logic       ref_clk, rst, mac_valid, mac_ready, scram_bypass, loop_enable;
    logic       line_ready, code_err, lvl, b, kb, lr_prev;
    logic [4:0] straps, cg;
    logic [1:0] lvp, last, lv;
    logic [10:0] ks;
    logic [14:0] first_w;
    fetx_nib_t  mac_nib;
    fetx_line_t line_out, loop_out, mw;
    logic [4:0] cg_q[$];
    logic       er_q[$];
    int         bad_count, cmp_count, cyc, nb, nw;

    fetx_coder dut_u (.ref_clk(ref_clk), .rst(rst), .mac_valid(mac_valid), .mac_nib(mac_nib),
        .mac_ready(mac_ready), .phy_address_straps(straps), .scram_bypass(scram_bypass),
        .loop_enable(loop_enable), .line_ready(line_ready), .line_out(line_out),
        .loop_out(loop_out), .code_err(code_err));
    fetx_mac_model mac_u (.ref_clk(ref_clk), .mac_ready(mac_ready), .mac_valid(mac_valid),
        .mac_nib(mac_nib));

    always #20 ref_clk = ~ref_clk;

    task automatic fail(input string m);
        $display("MISMATCH t=%0t %s", $time, m);
        bad_count++;
    endtask

    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok)
            fail(m);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // ==========================================================
    // Line monitor: undoes NRZI and scrambling, checks MLT-3 order.
    // The keystream is learnt from the first eleven idle bits and then predicted, so a
    // wrong feedback polynomial shows up as corrupted symbols.
    always @(negedge ref_clk)
    begin
        mw = loop_enable ? loop_out : line_out;
        if (rst)
        begin
            lvl = 1'b0; lvp = 2'b00; last = 2'b00; nb = 0; nw = 0; ks = '0;
        end
        else
        begin
            if (loop_enable)
                chk(line_out[14:0] === '0, "line driven in loopback");
            if (mw.valid)
            begin
                chk(lr_prev === 1'b1, "word after stalled cycle");
                if (nw < 3)
                    first_w = {first_w[9:0], mw.nrzi};
                nw++;
                for (int i = 4; i >= 0; i--)
                begin
                    b = mw.nrzi[i] ^ lvl;
                    lvl = mw.nrzi[i];
                    kb = scram_bypass ? 1'b0 : (nb < 11 ? ~b : ks[8] ^ ks[10]);
                    ks = {ks[9:0], kb};
                    nb++;
                    cg = {cg[3:0], b ^ kb};
                    lv = {mw.pos[i], mw.neg[i]};
                    chk(lv !== 2'b11 && !(lv != 0 && lvp != 0 && lv != lvp)
                        && !(lv != 0 && lvp == 0 && lv == last), "mlt3 order");
                    if (lv != 0)
                        last = lv;
                    lvp = lv;
                end
                cg_q.push_back(cg);
                er_q.push_back(code_err);
            end
        end
        lr_prev = line_ready;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail("timeout");
            test_done();
        end
    end

    task automatic do_reset(input logic byp, input logic [4:0] s);
        rst = 1'b1;
        scram_bypass = byp;
        straps = s;
        tick(6);
        chk(line_out === '0 && mac_ready === 1'b0, "outputs active in reset");
        rst = 1'b0;
        tick(2);
        chk(mac_ready === 1'b1, "not ready after reset");
        tick(20);
        chk(cg_q.size() > 8 && cg_q[$] === C_I, "no idle stream");
        cg_q.delete();
        er_q.delete();
    endtask

    task automatic send(input logic [3:0] d[$], input int bad_at, output logic [4:0] e[$]);
        e = {C_J, C_K, CG[5], CG[5]};
        repeat (4) mac_u.push('{1'b1, 1'b0, 4'h5});
        foreach (d[i])
        begin
            mac_u.push('{1'b1, i == bad_at, d[i]});
            e.push_back(i == bad_at ? C_H : CG[d[i]]);
        end
        repeat (4) mac_u.push('{1'b0, 1'b0, 4'h0});
        e = {e, C_T, C_R, C_I, C_I};
    endtask

    task automatic expect_seq(input logic [4:0] e[$], input string nm);
        int n;
        n = 0;
        while (n < 600 && (cg_q.size() == 0 || cg_q[0] === C_I))
        begin
            if (cg_q.size() == 0)
                tick(1);
            else
            begin
                void'(cg_q.pop_front());
                void'(er_q.pop_front());
            end
            n++;
        end
        while (n < 1200 && cg_q.size() < e.size())
        begin
            tick(1);
            n++;
        end
        chk(n < 1200, "frame missing");
        foreach (e[i])
            chk(cg_q[i] === e[i] && er_q[i] === (e[i] === C_H), nm);
        // Drop the judged symbols so the next frame is not matched against this one.
        repeat (e.size())
        begin
            if (cg_q.size() != 0)
            begin
                void'(cg_q.pop_front());
                void'(er_q.pop_front());
            end
        end
        $display("test %s done", nm);
    endtask

    task automatic t_frame();
        logic [3:0] d[$];
        logic [4:0] e[$];
        for (int i = 0; i < 16; i++)
            d.push_back(4'(i));
        send(d, -1, e);
        expect_seq(e, "frame");
    endtask

    task automatic t_error();
        logic [4:0] e[$];
        send('{4'h3, 4'h9, 4'hc}, 1, e);
        expect_seq(e, "halt");
    endtask

    task automatic t_stall();
        int         t0;
        logic [3:0] d[$];
        logic [4:0] e[$];
        line_ready = 1'b0;
        t0 = mac_u.taken;
        for (int i = 0; i < 20; i++)
            d.push_back(4'(i));
        send(d, -1, e);
        tick(40);
        chk(mac_u.taken - t0 == 16 && mac_ready === 1'b0, "fifo not full at 16");
        repeat (60)
        begin
            line_ready = ~line_ready;
            tick(1);
        end
        line_ready = 1'b1;
        expect_seq(e, "stall");
    endtask

    task automatic t_scram();
        logic [14:0] w0;
        logic [4:0]  e[$];
        do_reset(1'b0, 5'h00);
        w0 = first_w;
        do_reset(1'b0, 5'h13);
        chk(first_w !== w0, "seed ignores straps");
        send('{4'h0, 4'hf, 4'h7, 4'h8}, -1, e);
        expect_seq(e, "scramble");
        chk(ks !== '0, "keystream stuck at zero");
    endtask

    task automatic t_loop();
        logic [4:0] e[$];
        loop_enable = 1'b1;
        do_reset(1'b1, 5'h1f);
        send('{4'ha, 4'h5}, -1, e);
        expect_seq(e, "loopback");
        loop_enable = 1'b0;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        line_ready = 1'b1;
        loop_enable = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        cyc = 0;
        do_reset(1'b1, 5'h0a);
        t_frame();
        t_error();
        t_stall();
        t_scram();
        t_loop();
        test_done();
    end
endmodule
